// file: logic/tmc_timer_core.sv
// Module: 16-bit timer core with prescaler, overflow flag and latched count reads
//
// Chosen here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
// What this block does
// - Stop mode makes the timer inactive, all registers and count kept.
// - Leaving stop mode lets counting resume from the retained state.
// - During debug break the counter holds and does not advance.
// - With break_clear_enable set, flags clear during break and stay cleared.
// - With break_clear_enable clear, break accesses leave flags; armed clear finishes later.
// - Divider code 111 selects the external timer clock pin as count source.
// - External clock selected forces the pin to input; otherwise general purpose.
// - Overflow flag sets when the counter reaches the modulo value.
// - Flag clears by read-with-set then write 0; new overflow voids it.
// - Overflow interrupt requested while flag and enable set; reset clears enable.
// - counter_halt freezes counting; reset sets it.
// - counter_clear zeroes counter and prescaler, self-clears, reads 0.
// - Halt and clear in one write leave the counter stopped at zero.
// - Divider codes 000 to 110 divide bus clock by 1 to 64; reset clears.
// - High byte read latches low byte until low byte is read.
// - Count byte registers are read-only, zeroed by reset and clear.
// - After reaching modulo the counter restarts from zero next timer clock.
// - Modulo high write suppresses overflow until modulo low is written.
// - In wait mode the timer runs; enabled request wakes the processor.
module tmc_timer_core
    import tmc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Processor state
    input wire logic stop_mode_i,
    input wire logic break_active_i,
    // External timer clock pin (three signals)
    input wire logic ext_timer_clock_i,
    output logic ext_timer_clock_o,
    output logic ext_timer_clock_oe_o,
    // Events towards capture channels and processor
    output logic [15:0] count_o,
    output logic overflow_o,
    output logic overflow_irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    tmc_wb_req_type req;
    logic access;
    logic wr;
    logic rd;

    assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i, adr: adr_i, dat: dat_i};
    // One access per request; ack low in the cycle after it was given
    assign access = req.cyc && req.stb && !ack_o;
    assign wr = access && req.we && req.sel[0];
    assign rd = access && !req.we;

    ////////////////////////////////////////////////////////////////////////////
    // Registers and state

    logic [15:0] count;
    logic [15:0] modulo;
    logic [7:0] modulo_high_hold;
    logic [5:0] prescale;
    logic [2:0] clock_divide_select;
    logic overflow_flag;
    logic overflow_irq_enable;
    logic counter_halt;
    logic clear_armed;
    logic overflow_inhibit;
    logic low_latched;
    logic [7:0] low_latch;
    logic break_clear_enable;
    logic port_b_dir_bit3;
    logic pin_out_level;
    logic [1:0] ext_sample;
    logic tick;
    logic next_tick;
    logic reach;
    logic do_clear;
    logic flags_writable;

    assign do_clear = wr && req.adr == ADDR_STATUS_CONTROL && req.dat[BIT_COUNTER_CLEAR];
    // Break protects flags unless software allows clearing
    assign flags_writable = !break_active_i || break_clear_enable;
    assign reach = tick && count == modulo;

    ////////////////////////////////////////////////////////////////////////////
    // Timer clock select

    // Rising edge of the pin, sampled as synchronous input
    always_comb
    begin
        if (clock_divide_select == DIV_EXTERNAL)
        begin
            next_tick = ext_sample[0] && !ext_sample[1];
        end
        else
        begin
            // Divide by 2^code: fires when low code bits of prescaler are all ones
            next_tick = &(prescale | ~((6'h01 << clock_divide_select) - 6'h01));
        end
    end

    // Counting is gated by halt, break and stop; wait mode does not gate
    assign tick = next_tick && !counter_halt && !break_active_i && !stop_mode_i;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ext_sample <= 2'h0;
        end
        else
        begin
            ext_sample <= {ext_sample[0], ext_timer_clock_i};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler

    // Held with the counter so a resumed count keeps its phase
    always_ff @(posedge clk_i)
    begin
        if (rst_i || do_clear)
        begin
            prescale <= PRESCALE_ZERO;
        end
        else if (!counter_halt && !break_active_i && !stop_mode_i)
        begin
            prescale <= prescale + 6'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter

    always_ff @(posedge clk_i)
    begin
        if (rst_i || do_clear)
        begin
            count <= COUNT_ZERO;
        end
        else if (reach)
        begin
            count <= COUNT_ZERO;
        end
        else if (tick)
        begin
            count <= count + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Modulo registers

    // Low byte commits both halves, so a half-written modulo never compares
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            modulo <= MODULO_RESET;
            modulo_high_hold <= MODULO_RESET[15:8];
            overflow_inhibit <= 1'b0;
        end
        else if (wr && req.adr == ADDR_MODULO_HIGH)
        begin
            modulo_high_hold <= req.dat[7:0];
            overflow_inhibit <= 1'b1;
        end
        else if (wr && req.adr == ADDR_MODULO_LOW)
        begin
            modulo <= {modulo_high_hold, req.dat[7:0]};
            overflow_inhibit <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control bits

    // Halt and clear in one write: clear zeroes, halt then keeps it there
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            overflow_irq_enable <= 1'b0;
            counter_halt <= 1'b1;
            clock_divide_select <= DIV_RESET;
        end
        else if (wr && req.adr == ADDR_STATUS_CONTROL)
        begin
            overflow_irq_enable <= req.dat[BIT_OVERFLOW_IRQ_ENABLE];
            counter_halt <= req.dat[BIT_COUNTER_HALT];
            clock_divide_select <= req.dat[DIV_MSB:DIV_LSB];
        end
    end

    // Port control stands in for the system-level break clear enable
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            break_clear_enable <= 1'b0;
            port_b_dir_bit3 <= 1'b0;
            pin_out_level <= 1'b0;
        end
        else if (wr && req.adr == ADDR_PORT_CONTROL)
        begin
            break_clear_enable <= req.dat[BIT_BREAK_CLEAR_ENABLE];
            port_b_dir_bit3 <= req.dat[BIT_PORT_B_DIR_BIT3];
            pin_out_level <= req.dat[BIT_PIN_OUT_LEVEL];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Overflow flag and two-step clear

    // Set wins over a clear in the same cycle, so no overflow is lost
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            overflow_flag <= 1'b0;
            clear_armed <= 1'b0;
        end
        else if (reach && !overflow_inhibit)
        begin
            overflow_flag <= 1'b1;
            clear_armed <= 1'b0;
        end
        else if (wr && req.adr == ADDR_STATUS_CONTROL && flags_writable)
        begin
            // Writing 1 keeps the flag; writing 0 clears only when armed
            if (clear_armed && !req.dat[BIT_OVERFLOW_FLAG])
            begin
                overflow_flag <= 1'b0;
            end
            clear_armed <= 1'b0;
        end
        else if (rd && req.adr == ADDR_STATUS_CONTROL && overflow_flag && flags_writable)
        begin
            clear_armed <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Count byte latch

    // Released by a low read, reset or counter clear, so a latch taken in break outlives it
    always_ff @(posedge clk_i)
    begin
        if (rst_i || do_clear)
        begin
            low_latched <= 1'b0;
            low_latch <= COUNT_ZERO[7:0];
        end
        else if (rd && req.adr == ADDR_COUNT_HIGH && !low_latched)
        begin
            low_latched <= 1'b1;
            low_latch <= count[7:0];
        end
        else if (rd && req.adr == ADDR_COUNT_LOW)
        begin
            low_latched <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data and acknowledge

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= DATA_ZERO;
        end
        else
        begin
            ack_o <= access;
            dat_o <= DATA_ZERO;
            if (rd)
            begin
                unique case (req.adr)
                    ADDR_STATUS_CONTROL:
                        // Clear bit always reads 0
                        dat_o[7:0] <= {overflow_flag, overflow_irq_enable, counter_halt,
                            1'b0, 1'b0, clock_divide_select};
                    ADDR_COUNT_HIGH:
                        dat_o[7:0] <= count[15:8];
                    ADDR_COUNT_LOW:
                        dat_o[7:0] <= low_latched ? low_latch : count[7:0];
                    ADDR_MODULO_HIGH:
                        dat_o[7:0] <= modulo[15:8];
                    ADDR_MODULO_LOW:
                        dat_o[7:0] <= modulo[7:0];
                    ADDR_PORT_CONTROL:
                        dat_o[2:0] <= {pin_out_level, port_b_dir_bit3, break_clear_enable};
                    default:
                        dat_o <= DATA_ZERO;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            count_o <= COUNT_ZERO;
            overflow_o <= 1'b0;
            overflow_irq_o <= 1'b0;
            ext_timer_clock_o <= 1'b0;
            ext_timer_clock_oe_o <= 1'b0;
        end
        else
        begin
            count_o <= count;
            overflow_o <= reach && !overflow_inhibit;
            overflow_irq_o <= overflow_flag && overflow_irq_enable;
            ext_timer_clock_o <= pin_out_level;
            // Clock input use overrides the direction bit
            ext_timer_clock_oe_o <= port_b_dir_bit3 && clock_divide_select != DIV_EXTERNAL;
        end
    end

endmodule : tmc_timer_core

// file: logic/tmc_pkg.sv
// Package: register map, field positions and reset values of the timer core
package tmc_pkg;

    // Register word addresses (byte address, one aligned word each)
    localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h04;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h08;
    localparam logic [7:0] ADDR_MODULO_HIGH = 8'h0c;
    localparam logic [7:0] ADDR_MODULO_LOW = 8'h10;
    localparam logic [7:0] ADDR_PORT_CONTROL = 8'h14;

    // Status/control field positions
    localparam int BIT_OVERFLOW_FLAG = 7;
    localparam int BIT_OVERFLOW_IRQ_ENABLE = 6;
    localparam int BIT_COUNTER_HALT = 5;
    localparam int BIT_COUNTER_CLEAR = 4;
    localparam int DIV_LSB = 0;
    localparam int DIV_MSB = 2;

    // Port control field positions
    localparam int BIT_BREAK_CLEAR_ENABLE = 0;
    localparam int BIT_PORT_B_DIR_BIT3 = 1;
    localparam int BIT_PIN_OUT_LEVEL = 2;

    // Divider codes
    localparam logic [2:0] DIV_EXTERNAL = 3'h7;
    localparam logic [2:0] DIV_RESET = 3'h0;

    // Reset values
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [15:0] MODULO_RESET = 16'hffff;
    localparam logic [5:0] PRESCALE_ZERO = 6'h00;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    // Wishbone request as one carrier
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } tmc_wb_req_type;

endpackage : tmc_pkg

// file: dv/tmc_timer_core_props.sv
// Checker: bus handshake and counter timing properties of the timer core
`timescale 1ns/10ps
module tmc_timer_core_props
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Processor state
    input wire logic stop_mode_i,
    input wire logic break_active_i,
    // Events
    input wire logic [15:0] count_o,
    input wire logic overflow_o,
    input wire logic overflow_irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Request not yet answered
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    // Extra cycles cover the registered copy of the count
    sequence s_stopped;
        stop_mode_i [*4];
    endsequence
    sequence s_broken;
        break_active_i [*4];
    endsequence
    a_ack_follows_req: assert property (s_req |=> ack_o)
        else $error("ack missing after request");
    a_ack_one_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_data_idle_zero: assert property (!ack_o |-> dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
    a_stop_holds_count: assert property (s_stopped |-> $stable(count_o))
        else $error("count moved in stop mode");
    a_break_holds_count: assert property (s_broken |-> $stable(count_o))
        else $error("count moved in break");
    a_count_steps_one: assert property ($changed(count_o) |->
        count_o == $past(count_o) + 16'h0001 || count_o == 16'h0000)
        else $error("count jumped");
    a_overflow_wraps: assert property (overflow_o |-> ##[0:3] count_o == 16'h0000)
        else $error("count did not wrap after overflow");
    a_irq_has_cause: assert property ($rose(overflow_irq_o) |-> overflow_o
        || $past(overflow_o) || $past(overflow_o, 2) || $past(ack_o) || $past(ack_o, 2))
        else $error("irq rose without cause");
endmodule : tmc_timer_core_props

bind tmc_timer_core tmc_timer_core_props u_tmc_timer_core_props (.clk_i, .rst_i, .cyc_i,
    .stb_i, .dat_o, .ack_o, .stop_mode_i, .break_active_i, .count_o, .overflow_o,
    .overflow_irq_o);

// file: dv/tb_tmc_timer_core.sv
// Testbench: register-level tests of the timer core
`timescale 1ns/10ps
module tb_tmc_timer_core
    import tmc_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    tmc_wb_req_type req = '0;
    logic stop_i = 1'b0;
    logic brk_i = 1'b0;
    logic pin_i = 1'b0;
    logic [31:0] dat_o;
    logic ack_o;
    logic pin_oe;
    logic pin_lvl;
    logic irq;
    logic [15:0] cnt;
    logic [31:0] q;
    logic [15:0] v;
    int num_errors = 0;
    int samples_checked = 0;
    ////////////////////////////////////////
    always #4 clk_i = ~clk_i;
    tmc_timer_core u_tmc_timer_core (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(req.cyc),
        .stb_i(req.stb), .we_i(req.we), .sel_i(req.sel), .adr_i(req.adr),
        .dat_i(req.dat), .dat_o(dat_o), .ack_o(ack_o), .stop_mode_i(stop_i),
        .break_active_i(brk_i), .ext_timer_clock_i(pin_i), .ext_timer_clock_o(pin_lvl),
        .ext_timer_clock_oe_o(pin_oe), .count_o(cnt), .overflow_o(),
        .overflow_irq_o(irq));
    ////////////////////////////////////////
    task chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // Classic cycle, held until ack is sampled high
    // No wait-state count assumed; only the watchdog ends a stuck wait
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, w, 4'hf, a, {24'h0, d}};
        do
        begin
            @(posedge clk_i);
        end
        while (ack_o !== 1'b1);
        q = dat_o;
        req <= '0;
    endtask : bus
    task rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(q, {24'h0, e});
    endtask : rd
    // Guard cycles let the registered count settle first
    task meas(input int c, input logic [15:0] e);
        repeat (4) @(posedge clk_i);
        v = cnt;
        repeat (c) @(posedge clk_i);
        chk(16'(cnt - v), e);
    endtask : meas
    task wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 2000)
        begin
            @(posedge clk_i);
            n++;
        end
        chk(irq, 1'b1);
    endtask : wait_irq
    task tally_and_finish;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////
    // Watchdog well beyond the expected few thousand cycles
    initial
    begin
        #160000;
        num_errors++;
        tally_and_finish();
    end
    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(ADDR_STATUS_CONTROL, 8'h20);
        rd(ADDR_COUNT_HIGH, 8'h00);
        rd(ADDR_COUNT_LOW, 8'h00);
        rd(8'h18, 8'h00);
        meas(40, 16'h0000);
        $display("done reset");
        for (int k = 0; k < 7; k++)
        begin
            bus(1'b1, ADDR_STATUS_CONTROL, 8'(k));
            meas(128, 16'(128 >> k));
        end
        bus(1'b1, ADDR_STATUS_CONTROL, 8'h30);
        meas(20, 16'h0000);
        rd(ADDR_COUNT_HIGH, 8'h00);
        rd(ADDR_COUNT_LOW, 8'h00);
        rd(ADDR_STATUS_CONTROL, 8'h20);
        $display("done divide");
        bus(1'b1, ADDR_STATUS_CONTROL, 8'h00);
        @(posedge clk_i);
        brk_i <= 1'b1;
        meas(30, 16'h0000);
        brk_i <= 1'b0;
        meas(64, 16'h0040);
        stop_i <= 1'b1;
        meas(30, 16'h0000);
        stop_i <= 1'b0;
        meas(64, 16'h0040);
        $display("done freeze");
        // Low byte must come from the first high read, not the later count
        bus(1'b1, ADDR_STATUS_CONTROL, 8'h20);
        repeat (4) @(posedge clk_i);
        v = cnt;
        rd(ADDR_COUNT_HIGH, v[15:8]);
        bus(1'b1, ADDR_STATUS_CONTROL, 8'h00);
        repeat (300) @(posedge clk_i);
        bus(1'b0, ADDR_COUNT_HIGH, 8'h00);
        rd(ADDR_COUNT_LOW, v[7:0]);
        bus(1'b1, ADDR_COUNT_HIGH, 8'hff);
        bus(1'b1, ADDR_STATUS_CONTROL, 8'h20);
        repeat (4) @(posedge clk_i);
        v = cnt;
        rd(ADDR_COUNT_HIGH, v[15:8]);
        rd(ADDR_COUNT_LOW, v[7:0]);
        $display("done latch");
        bus(1'b1, ADDR_PORT_CONTROL, 8'h02);
        bus(1'b1, ADDR_STATUS_CONTROL, 8'h07);
        // Enable is registered a cycle after the divider write lands
        repeat (2) @(posedge clk_i);
        chk(pin_oe, 1'b0);
        // Idle pin: the bus clock must no longer count
        meas(8, 16'h0000);
        // Pin period of four bus cycles, below half the bus rate
        repeat (10)
        begin
            repeat (2) @(posedge clk_i);
            pin_i <= 1'b1;
            repeat (2) @(posedge clk_i);
            pin_i <= 1'b0;
        end
        repeat (6) @(posedge clk_i);
        chk(16'(cnt - v), 16'h000a);
        bus(1'b1, ADDR_STATUS_CONTROL, 8'h20);
        repeat (2) @(posedge clk_i);
        chk(pin_oe, 1'b1);
        bus(1'b1, ADDR_PORT_CONTROL, 8'h06);
        repeat (2) @(posedge clk_i);
        chk(pin_lvl, 1'b1);
        rd(ADDR_PORT_CONTROL, 8'h06);
        $display("done pin");
        bus(1'b1, ADDR_STATUS_CONTROL, 8'h30);
        bus(1'b1, ADDR_MODULO_HIGH, 8'h00);
        bus(1'b1, ADDR_MODULO_LOW, 8'h20);
        bus(1'b1, ADDR_STATUS_CONTROL, 8'h43);
        wait_irq();
        bus(1'b1, ADDR_STATUS_CONTROL, 8'h63);
        rd(ADDR_STATUS_CONTROL, 8'he3);
        @(posedge clk_i);
        brk_i <= 1'b1;
        bus(1'b1, ADDR_STATUS_CONTROL, 8'h63);
        rd(ADDR_STATUS_CONTROL, 8'he3);
        brk_i <= 1'b0;
        bus(1'b1, ADDR_STATUS_CONTROL, 8'h63);
        rd(ADDR_STATUS_CONTROL, 8'h63);
        chk(irq, 1'b0);
        bus(1'b1, ADDR_STATUS_CONTROL, 8'h43);
        wait_irq();
        bus(1'b1, ADDR_STATUS_CONTROL, 8'h63);
        bus(1'b1, ADDR_PORT_CONTROL, 8'h01);
        @(posedge clk_i);
        brk_i <= 1'b1;
        rd(ADDR_STATUS_CONTROL, 8'he3);
        // Counter halted: the count output has long settled
        v = cnt;
        rd(ADDR_COUNT_HIGH, v[15:8]);
        rd(ADDR_COUNT_LOW, v[7:0]);
        bus(1'b1, ADDR_STATUS_CONTROL, 8'h63);
        brk_i <= 1'b0;
        rd(ADDR_STATUS_CONTROL, 8'h63);
        // Arm the clear, let one more overflow pass, then the write must not clear
        bus(1'b1, ADDR_STATUS_CONTROL, 8'h43);
        wait_irq();
        rd(ADDR_STATUS_CONTROL, 8'hc3);
        repeat (300) @(posedge clk_i);
        bus(1'b1, ADDR_STATUS_CONTROL, 8'h63);
        rd(ADDR_STATUS_CONTROL, 8'he3);
        $display("done flag");
        tally_and_finish();
    end
endmodule : tb_tmc_timer_core
